//--- include/vcr_consts.vh
// Offsets, fields and reset values for the channel 0 resource registers.
// Assumes inclusion by the register bank only.
`ifndef VCR_CONSTS_VH
`define VCR_CONSTS_VH
`define VCR_CTL_OFFSET 12'h214
`define VCR_STS_OFFSET 12'h218
`define VCR_MAP_RESET 8'hff
`define VCR_MAP_MSB 7
`define VCR_LOAD_BIT 16
`define VCR_SEL_LSB 17
`define VCR_SEL_MSB 19
`define VCR_ID_VALUE 3'h0
`define VCR_ENABLE_VALUE 1'h1
`define VCR_COHERENCY_BIT 16
`define VCR_NEG_BIT 17
`define VCR_SEL_RESET 3'h0
`define VCR_TABLE_SCHEMES 8'hfe
`define VCR_ID_LSB 24
`define VCR_ID_MSB 26
`define VCR_ENABLE_BIT 31
`define VCR_NEG_VALUE 1'h0
`define VCR_MAP_LANE 0
`define VCR_SEL_LANE 2
`endif

//--- logic/vcr_resource_regs.v
// Channel 0 resource control and status registers of a switch port.
// Assumes a single-cycle configuration access port on clk (PCIe or SMBus
// side already merged) and an arbitration table loader on the same clock.
//
// Contract
// R1: Set map bit routes class to channel 0
// R2: Map resets all ones; bit0 read-only
// R3: Load trigger copies table into arbiter
// R4: Writing zero ignored; trigger reads zero
// R5: Trigger ignored unless scheme uses table
// R6: Software selects only capability-advertised schemes
// R7: Channel identifier read-only, fixed zero
// R8: Channel enable read-only, always one
// R9: Coherency sets on table write, clears after load
// R10: Coherency meaningful only for table schemes
// R11: Negotiation pending always reads zero
// R12: SMBus agents must not trust negotiation bit
// R13: Software polls coherency after load
// R14: Reserved bits read zero, ignore writes
`include "vcr_consts.vh"
`default_nettype none
module vcr_resource_regs (
  input wire clk,
  input wire reset_n,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [11:0] cfgAddr,
  input wire [31:0] cfgWriteData,
  input wire [3:0] cfgByteEnable,
  output reg [31:0] cfgReadData,
  input wire tableEntryWrite,
  input wire tableLoadDone,
  output reg tableLoadStart,
  output wire [7:0] classToChannelMap,
  output wire [2:0] portArbSchemeSelect
);

  // ****************************************
  // Field map
  // ****************************************
  localparam [11:0] CTL_OFFSET = `VCR_CTL_OFFSET;
  localparam [11:0] STS_OFFSET = `VCR_STS_OFFSET;
  localparam [7:0] MAP_RESET = `VCR_MAP_RESET;
  localparam [2:0] SEL_RESET = `VCR_SEL_RESET;
  localparam [2:0] ID_VALUE = `VCR_ID_VALUE;
  localparam [0:0] ENABLE_VALUE = `VCR_ENABLE_VALUE;
  localparam [0:0] NEG_VALUE = `VCR_NEG_VALUE;
  localparam [7:0] TABLE_SCHEMES = `VCR_TABLE_SCHEMES;
  localparam integer MAP_MSB = `VCR_MAP_MSB;
  localparam integer LOAD_BIT = `VCR_LOAD_BIT;
  localparam integer SEL_LSB = `VCR_SEL_LSB;
  localparam integer SEL_MSB = `VCR_SEL_MSB;
  localparam integer ID_LSB = `VCR_ID_LSB;
  localparam integer ID_MSB = `VCR_ID_MSB;
  localparam integer ENABLE_BIT = `VCR_ENABLE_BIT;
  localparam integer COHERENCY_BIT = `VCR_COHERENCY_BIT;
  localparam integer NEG_BIT = `VCR_NEG_BIT;
  localparam integer MAP_LANE = `VCR_MAP_LANE;
  localparam integer SEL_LANE = `VCR_SEL_LANE;

  // ****************************************
  // Decode
  // ****************************************
  // Word match; byte offset bits ignored
  function hitAddr;
    input [11:0] addr;
    input [11:0] offset;
    begin
      hitAddr = (addr[11:2] == offset[11:2]);
    end
  endfunction

  // One-hot of a scheme code
  function [7:0] schemeBit;
    input [2:0] scheme;
    begin
      schemeBit = 8'h01 << scheme;
    end
  endfunction

  wire ctlWrite;
  wire ctlRead;
  wire stsRead;
  wire mapLaneWrite;
  wire selLaneWrite;

  assign ctlWrite = cfgWrite && hitAddr(cfgAddr, CTL_OFFSET);
  assign ctlRead = cfgRead && hitAddr(cfgAddr, CTL_OFFSET);
  assign stsRead = cfgRead && hitAddr(cfgAddr, STS_OFFSET);
  // Lanes 1 and 3 hold nothing writable
  assign mapLaneWrite = ctlWrite && cfgByteEnable[MAP_LANE]; // R14
  assign selLaneWrite = ctlWrite && cfgByteEnable[SEL_LANE]; // R14

  // ****************************************
  // Class to channel map
  // ****************************************
  // Bit 0 is fixed; bits 7:1 are one flop each
  wire [7:0] mapBits;

  assign mapBits[0] = MAP_RESET[0]; // R2

  genvar mapIdx;
  generate
    for (mapIdx = 1; mapIdx <= MAP_MSB; mapIdx = mapIdx + 1) begin : gMapBit
      reg mapBit_reg;
      wire mapBit_next;

      assign mapBit_next = mapLaneWrite ? cfgWriteData[mapIdx] : mapBit_reg; // R2

      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mapBit_reg <= MAP_RESET[mapIdx]; // R2
        end else begin
          mapBit_reg <= mapBit_next;
        end
      end

      assign mapBits[mapIdx] = mapBit_reg;
    end
  endgenerate

  assign classToChannelMap = mapBits; // R1

  // ****************************************
  // Port arbitration scheme select
  // ****************************************
  reg [2:0] scheme_reg;
  reg [2:0] scheme_next;

  always @* begin
    scheme_next = scheme_reg;
    if (selLaneWrite) begin
      scheme_next = cfgWriteData[SEL_MSB:SEL_LSB];
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scheme_reg <= SEL_RESET;
    end else begin
      scheme_reg <= scheme_next;
    end
  end

  assign portArbSchemeSelect = scheme_reg;

  // ****************************************
  // Table load trigger
  // ****************************************
  // No storage: a one fires the loader when a table scheme is in force and it is idle, a zero does nothing
  wire tableScheme;
  wire loadReq;
  wire loadGo;
  reg loadBusy_reg;
  reg loadBusy_next;
  reg loadStart_next;

  // Judged against the scheme in force before this write
  assign tableScheme = |(schemeBit(scheme_reg) & TABLE_SCHEMES); // R10
  assign loadReq = selLaneWrite && cfgWriteData[LOAD_BIT]; // R4
  // A trigger while busy would restart the loader mid-copy
  assign loadGo = loadReq && tableScheme && !loadBusy_reg; // R5

  always @* begin
    loadStart_next = loadGo; // R3
    loadBusy_next = loadBusy_reg;
    if (loadGo) begin
      loadBusy_next = 1'b1;
    end else if (tableLoadDone) begin
      loadBusy_next = 1'b0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tableLoadStart <= 1'b0;
      loadBusy_reg <= 1'b0;
    end else begin
      tableLoadStart <= loadStart_next; // R3
      loadBusy_reg <= loadBusy_next;
    end
  end

  // ****************************************
  // Table coherency status
  // ****************************************
  reg coherency_reg;
  reg coherency_next;

  always @* begin
    coherency_next = coherency_reg;
    // Table write wins over same-cycle completion
    if (tableEntryWrite) begin
      coherency_next = 1'b1; // R9
    end else if (loadBusy_reg && tableLoadDone) begin
      coherency_next = 1'b0; // R9
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coherency_reg <= 1'b0;
    end else begin
      coherency_reg <= coherency_next;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  reg [31:0] ctlImage;
  reg [31:0] stsImage;
  reg [31:0] readData_next;

  always @* begin
    // Trigger and reserved fields read zero
    ctlImage = 32'h0; // R4 R14
    ctlImage[MAP_MSB:0] = classToChannelMap;
    ctlImage[SEL_MSB:SEL_LSB] = scheme_reg;
    ctlImage[ID_MSB:ID_LSB] = ID_VALUE; // R7
    ctlImage[ENABLE_BIT] = ENABLE_VALUE; // R8
  end

  always @* begin
    stsImage = 32'h0; // R14
    stsImage[COHERENCY_BIT] = coherency_reg; // R9
    stsImage[NEG_BIT] = NEG_VALUE; // R11
  end

  always @* begin
    readData_next = 32'h0;
    if (ctlRead) begin
      readData_next = ctlImage;
    end else if (stsRead) begin
      readData_next = stsImage;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgReadData <= 32'h0;
    end else begin
      cfgReadData <= readData_next;
    end
  end

endmodule // vcr_resource_regs
`default_nettype wire

//--- verif/vcr_regs_monitor.sv
// Concurrent checks on the register bank's ports.
// Assumes binding onto the bank, all ports on one clock.
`default_nettype none
module vcr_regs_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [11:0] cfgAddr,
  input wire logic [31:0] cfgWriteData,
  input wire logic [3:0] cfgByteEnable,
  input wire logic [31:0] cfgReadData,
  input wire logic tableEntryWrite,
  input wire logic tableLoadDone,
  input wire logic tableLoadStart,
  input wire logic [7:0] classToChannelMap,
  input wire logic [2:0] portArbSchemeSelect
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic wc = cfgWrite && cfgAddr == 12'h214;
  wire logic rs = cfgRead && cfgAddr == 12'h218;
  property p_m0; classToChannelMap[0]; endproperty
  a_m0: assert property (p_m0) else $error("map bit0");
  property p_map; wc && cfgByteEnable[0] |=> classToChannelMap[7:1] == $past(cfgWriteData[7:1]);
  endproperty
  a_map: assert property (p_map) else $error("map");
  property p_one; tableLoadStart |=> !tableLoadStart; endproperty
  a_one: assert property (p_one) else $error("start");
  property p_sel; wc && portArbSchemeSelect == 0 && cfgWriteData[19:17] == 0 |=> !tableLoadStart;
  endproperty
  a_sel: assert property (p_sel) else $error("scheme");
  property p_zero; wc && !cfgWriteData[16] |=> !tableLoadStart; endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_ctl; cfgRead && cfgAddr == 12'h214 |=> (cfgReadData & 32'hfff1ff00) == 32'h80000000;
  endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_sts; rs |=> (cfgReadData & 32'hfffeffff) == 0; endproperty
  a_sts: assert property (p_sts) else $error("sts");
  sequence s_entryWritten; tableEntryWrite ##1 !tableLoadDone; endsequence
  property p_coh; s_entryWritten ##1 rs |=> cfgReadData[16]; endproperty
  a_coh: assert property (p_coh) else $error("coh");
endmodule // vcr_regs_monitor
`default_nettype wire

//--- verif/vcr_resource_regs_bench.sv
// Bench for the register bank; assumes design and checker compiled first.
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t value", $time); end end
module vcr_resource_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, cfgWrite = 0, cfgRead = 0, tableEntryWrite = 0, tableLoadDone = 0;
  logic [11:0] cfgAddr = 0;
  logic [31:0] cfgWriteData = 0;
  logic [3:0] cfgByteEnable = 4'hf;
  wire [31:0] cfgReadData;
  wire [7:0] classToChannelMap;
  wire [2:0] portArbSchemeSelect;
  wire tableLoadStart;
  int errors = 0, numChecks = 0, cycles = 0;
  always #4 clk = ~clk;
  vcr_resource_regs dut (
    .clk(clk),
    .reset_n(reset_n),
    .cfgWrite(cfgWrite),
    .cfgRead(cfgRead),
    .cfgAddr(cfgAddr),
    .cfgWriteData(cfgWriteData),
    .cfgByteEnable(cfgByteEnable),
    .cfgReadData(cfgReadData),
    .tableEntryWrite(tableEntryWrite),
    .tableLoadDone(tableLoadDone),
    .tableLoadStart(tableLoadStart),
    .classToChannelMap(classToChannelMap),
    .portArbSchemeSelect(portArbSchemeSelect)
  );
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk) {cfgWrite, cfgAddr, cfgWriteData, cfgByteEnable} <= {1'b1, a, d, b};
    @(posedge clk) cfgWrite <= 0;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk) {cfgRead, cfgAddr} <= {1'b1, a};
    @(posedge clk) cfgRead <= 0;
    #1 `CHK(cfgReadData, e)
  endtask
  task complete_run;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 500) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    rd(12'h214, 32'h800000ff);
    rd(12'h218, 32'h0);
    $display("reset test done");
    wr(12'h214, 32'h00010000, 4'hf);
    `CHK(tableLoadStart, 1'b0)
    wr(12'h214, 32'h00020000, 4'hf);
    `CHK(classToChannelMap, 8'h01)
    `CHK(portArbSchemeSelect, 3'h1)
    wr(12'h214, 32'h00030000, 4'hf);
    `CHK(tableLoadStart, 1'b1)
    rd(12'h214, 32'h80020001);
    $display("load test done");
    @(posedge clk) tableEntryWrite <= 1;
    @(posedge clk) tableEntryWrite <= 0;
    rd(12'h218, 32'h00010000);
    @(posedge clk) tableLoadDone <= 1;
    @(posedge clk) tableLoadDone <= 0;
    rd(12'h218, 32'h0);
    $display("coherency test done");
    wr(12'h214, 32'h7ff1fffe, 4'hf);
    `CHK(tableLoadStart, 1'b1)
    rd(12'h214, 32'h800000ff);
    wr(12'h214, 32'h00000000, 4'h0);
    `CHK(classToChannelMap, 8'hff)
    $display("reserved test done");
    @(posedge clk) {tableEntryWrite, tableLoadDone} <= 2'b11;
    @(posedge clk) {tableEntryWrite, tableLoadDone} <= 2'b00;
    rd(12'h218, 32'h00010000);
    @(posedge clk) tableLoadDone <= 1;
    @(posedge clk) tableLoadDone <= 0;
    rd(12'h218, 32'h00010000);
    $display("table write test done");
    complete_run;
  end
endmodule // vcr_resource_regs_bench
bind vcr_resource_regs vcr_regs_monitor mon (
  .clk(clk),
  .reset_n(reset_n),
  .cfgWrite(cfgWrite),
  .cfgRead(cfgRead),
  .cfgAddr(cfgAddr),
  .cfgWriteData(cfgWriteData),
  .cfgByteEnable(cfgByteEnable),
  .cfgReadData(cfgReadData),
  .tableEntryWrite(tableEntryWrite),
  .tableLoadDone(tableLoadDone),
  .tableLoadStart(tableLoadStart),
  .classToChannelMap(classToChannelMap),
  .portArbSchemeSelect(portArbSchemeSelect)
);
`default_nettype wire
